/* design/test_ctrl_pkg.sv */
// Constants and types shared by the manufacturing test control logic
package test_ctrl_pkg;
	// Scan chain count and lengths
	localparam int CHAIN_COUNT = 4;
	localparam int CHAIN_ONE_LEN = 908;
	localparam int CHAIN_TWO_LEN = 879;
	localparam int CHAIN_THREE_LEN = 21;
	localparam int CHAIN_FOUR_LEN = 235;
	// Isolated memory geometry
	localparam int MEM_ADDR_W = 6;
	localparam int MEM_DATA_W = 32;
	localparam int MEM_DEPTH = 64;
	// Read data field positions on the output pins
	localparam int RD_ADDR_LSB = 16;
	localparam int RD_DACK_LSB = 8;
	localparam int RD_WR_BIT = 7;
	localparam int RD_RD_BIT = 6;
	localparam int RD_INTACK_LSB = 4;
	localparam int RD_CS_LSB = 0;
	// Address/strobe positions on the local data pins
	localparam int ISO_STROBE_BIT = 6;
	// Reset value of the held read word
	localparam logic [31:0] RD_RESET = 32'h0000_0000;
	// Test instruction codes seen on the instruction input
	localparam logic [1:0] INSTR_NONE = 2'h0;
	localparam logic [1:0] INSTR_RAM_ISO = 2'h1;
	localparam logic [1:0] INSTR_HIGHZ = 2'h2;
	// Test mode as decoded
	typedef enum logic [1:0] {MODE_FUNC, MODE_SCAN, MODE_RAM, MODE_FLOAT} test_mode_e;
endpackage

/* design/scan_chain_if.sv */
// Interface carrying one scan chain's serial controls
`timescale 1ns/1ns
`default_nettype none
interface scan_chain_if;
	logic shift_en; // Shift select, active high inside
	logic ser_in; // Serial input
	logic ser_out; // Serial output
	logic [31:0] capture; // Functional value captured
	modport chain (input shift_en, input ser_in, input capture, output ser_out);
	modport ctrl (output shift_en, output ser_in, output capture, input ser_out);
endinterface
`default_nettype wire

/* design/scan_chain.sv */
// One parameterised scan chain of fixed length
`timescale 1ns/1ns
`default_nettype none
module scan_chain
	import test_ctrl_pkg::*;
#(
	parameter int LEN = 21
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// Chain controls
	scan_chain_if.chain sc
);
	// All chain state in one struct
	typedef struct packed {
		logic [LEN-1:0] bits;
	} chain_s;
	chain_s state_q;
	chain_s state_d;

	// Shift when selected, else capture functional data
	always_comb begin
		state_d = state_q;
		if (sc.shift_en) begin
			state_d.bits = {state_q.bits[LEN-2:0], sc.ser_in};
		end else begin
			// Sized to the chain: short chains keep only the low capture bits
			state_d.bits = LEN'(sc.capture);
		end
	end

	// Register the chain
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	// Last stage leaves on the serial output
	assign sc.ser_out = state_q.bits[LEN-1];

	// Chain moves one stage per shift cycle
	shift_moves_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		sc.shift_en |=> state_q.bits[0] == $past(sc.ser_in))
		else $error("chain did not shift");
endmodule
`default_nettype wire

/* design/test_ctrl.sv */
// Manufacturing test control: scan chains, memory isolation, float
//
// How it works
// - Four scan chains, own serial pins.
// - Chain lengths 908, 879, 21, 235.
// - Chain three on reference clock.
// - Low scan-mode input enters scan test.
// - Low shift-select shifts patterns through chains.
// - Isolation instruction wires memory to pins.
// - Address, strobe, write data from pins.
// - Read data spread onto output pins.
// - Float input tri-states all but exempt.
// - HIGHZ instruction also floats outputs.
//
// Limits and trade-offs
// One shared enable covers all floating pins; exempt pins have none.
// Board must still float drivers in reset through the float input.
// Scan wins over isolation and float in the registered mode.
// Chain three shares the shift select with the main-clock chains,
// so the tester must hold the select steady across both clocks.
`timescale 1ns/1ns
`default_nettype none
module test_ctrl
	import test_ctrl_pkg::*;
(
	// Clocks and reset
	input wire logic i_clk,
	input wire logic i_reference_clock,
	input wire logic i_reset_n,
	// Test controls
	input wire logic i_scan_mode_select_n,
	input wire logic i_chain_shift_select_n,
	input wire logic i_output_float_force,
	input wire logic [1:0] i_instruction,
	// Serial inputs of the four chains
	input wire logic i_local_dma_request_7,
	input wire logic i_local_int_3,
	input wire logic i_local_bus_error_n,
	input wire logic i_multi_master_in,
	// Serial outputs of the four chains
	output logic o_chain_one_serial_out,
	output logic o_led_drive_enable_n,
	output logic o_local_reset_n,
	output logic o_multi_master_out,
	// Functional values of the exempt pins
	input wire logic i_func_led_n,
	input wire logic i_func_reset_n,
	input wire logic i_func_mm_out,
	input wire logic i_func_chain_one,
	// Local data pins in
	input wire logic [7:0] i_local_data,
	// Bus address/data pins in
	input wire logic [31:0] i_bus_ad,
	// Functional values of isolation pins
	input wire logic [15:0] i_func_local_addr,
	input wire logic [7:0] i_func_dma_ack_n,
	input wire logic i_func_wr_n,
	input wire logic i_func_rd_n,
	input wire logic [1:0] i_func_int_ack_n,
	input wire logic [3:0] i_func_cs_n,
	// Isolation pins out
	output logic [15:0] o_local_addr,
	output logic [7:0] o_local_dma_ack_n,
	output logic o_local_wr_n,
	output logic o_local_rd_n,
	output logic [1:0] o_local_int_ack_n,
	output logic [3:0] o_local_cs_n,
	// Pin driver enables
	output logic o_pin_oe,
	output logic o_test_mode_active
);
	// Control state: held read word and mode
	typedef struct packed {
		logic [MEM_DATA_W-1:0] rd_word;
		test_mode_e mode;
	} ctrl_s;
	ctrl_s state_q;
	ctrl_s state_d;

	// Isolated memory array, owned here
	logic [MEM_DATA_W-1:0] mem_q [MEM_DEPTH];
	logic [MEM_ADDR_W-1:0] iso_mem_address;
	logic iso_mem_write_strobe;
	logic [MEM_DATA_W-1:0] iso_mem_write_data;
	logic [MEM_DATA_W-1:0] iso_mem_read_data;
	logic ram_isolation_instruction;
	logic highz_instruction;
	logic scan_on;
	logic shift_on;
	logic strobe_prev_q;

	// Instruction decode
	assign ram_isolation_instruction = (i_instruction == INSTR_RAM_ISO);
	assign highz_instruction = (i_instruction == INSTR_HIGHZ);
	assign scan_on = !i_scan_mode_select_n;
	assign shift_on = scan_on && !i_chain_shift_select_n;

	// Isolation inputs come straight from pins
	assign iso_mem_address = i_local_data[MEM_ADDR_W-1:0];
	assign iso_mem_write_strobe = i_local_data[ISO_STROBE_BIT];
	assign iso_mem_write_data = i_bus_ad;
	assign iso_mem_read_data = state_q.rd_word;

	// Four chain interfaces, one per generate entry
	scan_chain_if sc_if [CHAIN_COUNT] ();
	logic [CHAIN_COUNT-1:0] chain_in;
	logic [CHAIN_COUNT-1:0] chain_out;
	assign chain_in = {i_multi_master_in, i_local_bus_error_n, i_local_int_3,
		i_local_dma_request_7};

	// One chain per entry; entry two on the reference clock
	localparam int LENS [CHAIN_COUNT] = '{CHAIN_ONE_LEN, CHAIN_TWO_LEN, CHAIN_THREE_LEN,
		CHAIN_FOUR_LEN};
	for (genvar g = 0; g < CHAIN_COUNT; g++) begin : g_chain
		assign sc_if[g].shift_en = shift_on;
		assign sc_if[g].ser_in = chain_in[g];
		assign sc_if[g].capture = {state_q.rd_word[31:1], i_bus_ad[g]};
		assign chain_out[g] = sc_if[g].ser_out;
		scan_chain #(.LEN(LENS[g])) u_chain (
			.i_clk((g == 2) ? i_reference_clock : i_clk),
			.i_reset_n(i_reset_n),
			.sc(sc_if[g])
		);
	end

	// Mode selection, scan has priority
	always_comb begin
		state_d = state_q;
		if (scan_on) begin
			state_d.mode = MODE_SCAN;
		end else if (ram_isolation_instruction) begin
			state_d.mode = MODE_RAM;
		end else if (i_output_float_force || highz_instruction) begin
			state_d.mode = MODE_FLOAT;
		end else begin
			state_d.mode = MODE_FUNC;
		end
		// Read word refreshes every cycle while isolated
		if (ram_isolation_instruction) begin
			state_d.rd_word = mem_q[iso_mem_address];
		end
	end

	// Register control state
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			state_q <= '{rd_word: RD_RESET, mode: MODE_FUNC};
			strobe_prev_q <= 1'b0;
		end else begin
			state_q <= state_d;
			strobe_prev_q <= iso_mem_write_strobe;
		end
	end

	// Memory write on strobe high; no reset, it is storage
	always_ff @(posedge i_clk) begin
		if (ram_isolation_instruction && iso_mem_write_strobe) begin
			mem_q[iso_mem_address] <= iso_mem_write_data;
		end
	end

	// Output muxing: isolation overrides functional values
	always_comb begin
		if (state_q.mode == MODE_RAM) begin
			o_local_addr = iso_mem_read_data[31:RD_ADDR_LSB];
			o_local_dma_ack_n = iso_mem_read_data[RD_ADDR_LSB-1:RD_DACK_LSB];
			o_local_wr_n = iso_mem_read_data[RD_WR_BIT];
			o_local_rd_n = iso_mem_read_data[RD_RD_BIT];
			o_local_int_ack_n = iso_mem_read_data[RD_RD_BIT-1:RD_INTACK_LSB];
			o_local_cs_n = iso_mem_read_data[RD_INTACK_LSB-1:RD_CS_LSB];
		end else begin
			o_local_addr = i_func_local_addr;
			o_local_dma_ack_n = i_func_dma_ack_n;
			o_local_wr_n = i_func_wr_n;
			o_local_rd_n = i_func_rd_n;
			o_local_int_ack_n = i_func_int_ack_n;
			o_local_cs_n = i_func_cs_n;
		end
	end

	// Floating drops enables, exempt pins never float
	assign o_pin_oe = !(i_output_float_force || highz_instruction);
	assign o_test_mode_active = (state_q.mode != MODE_FUNC);

	// Exempt pins carry chain outputs while scanning
	assign o_chain_one_serial_out = scan_on ? chain_out[0] : i_func_chain_one;
	assign o_led_drive_enable_n = scan_on ? chain_out[1] : i_func_led_n;
	assign o_local_reset_n = scan_on ? chain_out[2] : i_func_reset_n;
	assign o_multi_master_out = scan_on ? chain_out[3] : i_func_mm_out;

	// Assertions: driver enables
	// Float pin alone must drop the shared enable
	float_pin_off_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		i_output_float_force
		|-> !o_pin_oe)
		else $error("float input did not disable drivers");
	// Instruction path floats independently of the pin
	highz_off_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		highz_instruction
		|-> !o_pin_oe)
		else $error("highz did not disable drivers");
	// Neither float source: drivers stay on
	oe_on_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		!i_output_float_force && !highz_instruction
		|-> o_pin_oe)
		else $error("drivers off without float request");

	// Assertions: mode register
	// Scan select low wins on the next edge
	scan_mode_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		!i_scan_mode_select_n
		|=> state_q.mode == MODE_SCAN)
		else $error("scan mode not entered");
	// Enable is combinational, the mode follows an edge later
	func_mode_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(i_scan_mode_select_n && i_chain_shift_select_n && i_instruction == INSTR_NONE
		&& !i_output_float_force)
		|-> o_pin_oe ##1 state_q.mode == MODE_FUNC)
		else $error("not functional with tests off");
	// Isolation instruction outside scan selects memory mode
	iso_mode_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		ram_isolation_instruction && !scan_on
		|=> state_q.mode == MODE_RAM)
		else $error("isolation mode not entered");
	// Float pin with no scan and no isolation selects float mode
	float_mode_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		!scan_on && !ram_isolation_instruction && i_output_float_force
		|=> state_q.mode == MODE_FLOAT)
		else $error("float mode not entered");
	// High-impedance instruction outside scan selects float mode
	highz_mode_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		!scan_on && highz_instruction
		|=> state_q.mode == MODE_FLOAT)
		else $error("highz mode not entered");

	// Assertions: isolated memory
	// Two isolated cycles: read word reaches the address pins
	ram_read_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(ram_isolation_instruction && scan_on == 1'b0) [*2]
		|-> o_local_addr == state_q.rd_word[31:16])
		else $error("read data not on address pins");
	// Written word comes back at the same address
	ram_write_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(ram_isolation_instruction && iso_mem_write_strobe) ##1
		(ram_isolation_instruction && !iso_mem_write_strobe &&
		iso_mem_address == $past(iso_mem_address))
		|=> state_q.rd_word == $past(i_bus_ad, 2))
		else $error("written word not read back");
	// Read word frozen while the instruction is off
	rd_hold_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		!ram_isolation_instruction
		|=> state_q.rd_word == $past(state_q.rd_word))
		else $error("read word moved outside isolation");
	// High half on the local address pins
	addr_field_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		state_q.mode == MODE_RAM
		|-> o_local_addr == state_q.rd_word[31:16])
		else $error("high read bits misplaced");
	// Middle byte on the acknowledge outputs
	dack_field_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		state_q.mode == MODE_RAM
		|-> o_local_dma_ack_n == state_q.rd_word[15:8])
		else $error("middle read bits misplaced");
	// Bits seven and six on the strobes
	strobe_field_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		state_q.mode == MODE_RAM
		|-> o_local_wr_n == state_q.rd_word[7] && o_local_rd_n == state_q.rd_word[6])
		else $error("strobe read bits misplaced");
	// Low bits on interrupt acknowledges and selects
	cs_field_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		state_q.mode == MODE_RAM
		|-> o_local_cs_n == state_q.rd_word[3:0] && o_local_int_ack_n == state_q.rd_word[5:4])
		else $error("low read bits misplaced");

	// Assertions: functional pass-through
	// Outside isolation the bus pins show functional values
	func_pass_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		state_q.mode != MODE_RAM
		|-> o_local_addr == i_func_local_addr && o_local_dma_ack_n == i_func_dma_ack_n)
		else $error("functional address pins overridden");
	// Same for strobes, acknowledges and selects
	func_ctrl_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		state_q.mode != MODE_RAM
		|-> o_local_wr_n == i_func_wr_n && o_local_rd_n == i_func_rd_n
		&& o_local_int_ack_n == i_func_int_ack_n && o_local_cs_n == i_func_cs_n)
		else $error("functional control pins overridden");
	// Exempt pins keep functional values outside scan, even floating
	exempt_func_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		!scan_on
		|-> o_chain_one_serial_out == i_func_chain_one && o_led_drive_enable_n == i_func_led_n)
		else $error("exempt pins disturbed");
	// Remaining exempt pins likewise
	exempt_rest_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		!scan_on
		|-> o_local_reset_n == i_func_reset_n && o_multi_master_out == i_func_mm_out)
		else $error("exempt reset or master pin disturbed");

	// Assertions: scan chains
	// Chain one leaves on its own pin
	chain_one_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		scan_on
		|-> o_chain_one_serial_out == chain_out[0])
		else $error("chain one not on its output");
	// Chain two leaves on the led enable pin
	chain_two_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		scan_on
		|-> o_led_drive_enable_n == chain_out[1])
		else $error("chain two not on its output");
	// Chain three, reference clocked, leaves on the reset pin
	chain_three_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		scan_on
		|-> o_local_reset_n == chain_out[2])
		else $error("chain three not on its output");
	// Chain four leaves on the master output
	chain_out_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		scan_on
		|-> o_multi_master_out == chain_out[3])
		else $error("chain four not on its output");
	// Select high never shifts
	shift_sel_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		i_chain_shift_select_n
		|-> !sc_if[0].shift_en)
		else $error("shift with select high");
	// Shift select alone, outside scan, never shifts
	no_shift_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		i_scan_mode_select_n
		|-> !sc_if[0].shift_en)
		else $error("shift outside scan");
	// Every chain shifts together
	shift_all_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		shift_on
		|-> sc_if[1].shift_en && sc_if[2].shift_en && sc_if[3].shift_en)
		else $error("a chain missed the shift select");

	// Main scenarios
	scan_seen_c: cover property (@(posedge i_clk) disable iff (!i_reset_n) shift_on [*3]);
	ram_wr_c: cover property (@(posedge i_clk) disable iff (!i_reset_n)
		ram_isolation_instruction && iso_mem_write_strobe && !strobe_prev_q);
	ram_rd_c: cover property (@(posedge i_clk) disable iff (!i_reset_n)
		state_q.mode == MODE_RAM && !iso_mem_write_strobe);
	float_c: cover property (@(posedge i_clk) disable iff (!i_reset_n) i_output_float_force);
	highz_c: cover property (@(posedge i_clk) disable iff (!i_reset_n) highz_instruction);
endmodule
`default_nettype wire

/* verif/tester_model.sv */
// Production tester model: scan controls, float pin, reference clock
`timescale 1ns/1ns
`default_nettype none
module tester_model (
	// Requests from the bench
	input wire logic i_reset_n,
	input wire logic i_scan,
	input wire logic i_shift,
	input wire logic i_float,
	input wire logic i_ref_run,
	// Pins towards the device
	output logic o_scan_mode_select_n,
	output logic o_chain_shift_select_n,
	output logic o_output_float_force,
	output var logic o_reference_clock
);
	// Held high outside scan, as a pull-up would
	assign o_scan_mode_select_n = ~i_scan;
	// Shift only inside a scan frame, else held high
	assign o_chain_shift_select_n = ~(i_scan & i_shift);
	// Inverted reset floats drivers, since reset alone does not
	assign o_output_float_force = ~i_reset_n | i_float;
	// Reference clock stands still outside scan frames
	initial o_reference_clock = 1'b0;
	always #7 if (i_ref_run) o_reference_clock = ~o_reference_clock;
endmodule
`default_nettype wire

/* verif/test_manufacturing_test_control.sv */
// Self-checking bench for the manufacturing test control block
`timescale 1ns/1ns
`default_nettype none
module test_manufacturing_test_control;
	import test_ctrl_pkg::*;
	// Bench drives
	logic i_clk = 1'b0;
	logic rst_n = 1'b0;
	logic scan = 1'b0;
	logic shift = 1'b0;
	logic flt = 1'b0;
	logic ref_run = 1'b0;
	logic [1:0] instr = INSTR_NONE;
	logic [3:0] ser = 4'h0;
	logic [3:0] fn = 4'hA;
	logic [7:0] ld = 8'h00;
	logic [31:0] ad = 32'h0000_0000;
	logic [31:0] fw = 32'h5A5A_C3C3;
	// Observed pins
	wire [3:0] so;
	wire [31:0] iso;
	wire oe, tma, reference_clock, scan_n, shift_n, ff;
	int n_fail = 0;
	int tests_run = 0;
	// Main clock, 10 ns
	always #5 i_clk = ~i_clk;
	tester_model u_tester (.i_reset_n(rst_n), .i_scan(scan), .i_shift(shift), .i_float(flt),
		.i_ref_run(ref_run), .o_scan_mode_select_n(scan_n), .o_chain_shift_select_n(shift_n),
		.o_output_float_force(ff), .o_reference_clock(reference_clock));
	test_ctrl u_dut (.i_clk(i_clk), .i_reference_clock(reference_clock), .i_reset_n(rst_n),
		.i_scan_mode_select_n(scan_n), .i_chain_shift_select_n(shift_n),
		.i_output_float_force(ff), .i_instruction(instr),
		.i_local_dma_request_7(ser[0]), .i_local_int_3(ser[1]), .i_local_bus_error_n(ser[2]),
		.i_multi_master_in(ser[3]), .o_chain_one_serial_out(so[0]),
		.o_led_drive_enable_n(so[1]), .o_local_reset_n(so[2]), .o_multi_master_out(so[3]),
		.i_func_led_n(fn[1]), .i_func_reset_n(fn[2]), .i_func_mm_out(fn[3]),
		.i_func_chain_one(fn[0]), .i_local_data(ld), .i_bus_ad(ad),
		.i_func_local_addr(fw[31:16]), .i_func_dma_ack_n(fw[15:8]), .i_func_wr_n(fw[7]),
		.i_func_rd_n(fw[6]), .i_func_int_ack_n(fw[5:4]), .i_func_cs_n(fw[3:0]),
		.o_local_addr(iso[31:16]), .o_local_dma_ack_n(iso[15:8]), .o_local_wr_n(iso[7]),
		.o_local_rd_n(iso[6]), .o_local_int_ack_n(iso[5:4]), .o_local_cs_n(iso[3:0]),
		.o_pin_oe(oe), .o_test_mode_active(tma));
	// Compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Verdict and end of run
	task automatic wrap_up();
		if (n_fail == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Let edges pass, then settle off the edge
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	// Switch instruction; the mode lands one edge later
	task automatic set_instr(input logic [1:0] v);
		@(posedge i_clk);
		instr <= v;
		cyc(2);
	endtask
	// Isolated memory write, strobe high for one edge
	task automatic mem_wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge i_clk);
		ld <= {2'b01, a};
		ad <= d;
		@(posedge i_clk);
		ld <= {2'b00, a};
		ad <= ~d;
	endtask
	// Isolated memory read, word spread over the output pins
	task automatic mem_rd(input logic [5:0] a, input logic [31:0] exp);
		@(posedge i_clk);
		ld <= {2'b00, a};
		cyc(2);
		chk(iso, exp);
	endtask
	// Transparent pins in functional mode
	task automatic func_test();
		set_instr(INSTR_NONE);
		chk(iso, fw);
		chk(32'(so), 32'(fn));
		chk(tma, 1'b0);
	endtask
	// Isolation: boundary addresses back to back, refused write outside
	task automatic iso_test();
		set_instr(INSTR_RAM_ISO);
		chk(tma, 1'b1);
		mem_wr(6'h00, 32'h1234_ABCD);
		mem_wr(6'h3F, 32'hFEDC_5678);
		mem_rd(6'h3F, 32'hFEDC_5678);
		mem_rd(6'h00, 32'h1234_ABCD);
		set_instr(INSTR_NONE);
		mem_wr(6'h00, 32'h0BAD_F00D);
		cyc(1);
		chk(iso, fw);
		set_instr(INSTR_RAM_ISO);
		mem_rd(6'h00, 32'h1234_ABCD);
		set_instr(INSTR_NONE);
	endtask
	// Float pin and high-impedance instruction
	task automatic float_test();
		@(posedge i_clk);
		flt <= 1'b1;
		cyc(1);
		chk(oe, 1'b0);
		chk(32'(so), 32'(fn));
		@(posedge i_clk);
		flt <= 1'b0;
		set_instr(INSTR_HIGHZ);
		chk(oe, 1'b0);
		set_instr(INSTR_NONE);
		chk(oe, 1'b1);
	endtask
	// One edge of the clock that drives chain c
	task automatic tick(input int c);
		if (c == 2) @(posedge reference_clock);
		else @(posedge i_clk);
	endtask
	// Flush a chain, then time a single one through it
	task automatic chain_test(input int c, input int len);
		int n;
		@(posedge i_clk);
		scan <= 1'b1;
		shift <= 1'b1;
		ref_run <= 1'b1;
		ser <= 4'h0;
		repeat (len + 2) tick(c);
		#1;
		chk(tma, 1'b1);
		chk({31'h0, so[c]}, 32'h0);
		tick(c);
		ser[c] <= 1'b1;
		tick(c);
		ser[c] <= 1'b0;
		n = 1;
		#1;
		// Bounded so a stuck chain cannot hang the run
		while (so[c] !== 1'b1 && n < 1100) begin
			tick(c);
			#1;
			n++;
		end
		chk(n, len);
		if (n >= 1100) wrap_up();
		@(posedge i_clk);
		scan <= 1'b0;
		shift <= 1'b0;
		ref_run <= 1'b0;
	endtask
	// Main sequence
	initial begin
		repeat (16) @(posedge i_clk);
		#1;
		chk(oe, 1'b0);
		@(posedge i_clk);
		rst_n <= 1'b1;
		cyc(2);
		chk(oe, 1'b1);
		func_test();
		iso_test();
		float_test();
		chain_test(0, CHAIN_ONE_LEN);
		chain_test(1, CHAIN_TWO_LEN);
		chain_test(2, CHAIN_THREE_LEN);
		chain_test(3, CHAIN_FOUR_LEN);
		func_test();
		wrap_up();
	end
endmodule
`default_nettype wire
